// ### core/chg_defines.svh
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH
// Register addresses on the byte-wide register port.
`define CHG_ADDR_CONFIG_ONE 8'h49
`define CHG_ADDR_CONFIG_TWO 8'h4A
`define CHG_ADDR_CONFIG_THREE 8'h4B
// Reset values loaded into the three configuration registers.
`define CHG_RST_CONFIG_ONE 8'h0C
`define CHG_RST_CONFIG_TWO 8'h1A
`define CHG_RST_CONFIG_THREE 8'h80
// Field positions in the first configuration register.
`define CHG_ONE_TMR_HI 7
`define CHG_ONE_TMR_LO 6
`define CHG_ONE_DISCHARGE 5
`define CHG_ONE_THERM_BIAS 4
`define CHG_ONE_ISCALE_HI 3
`define CHG_ONE_ISCALE_LO 2
`define CHG_ONE_TERM_OFF 1
`define CHG_ONE_SUSPEND 0
// Field positions in the second configuration register.
`define CHG_TWO_DYN_TIMER 7
`define CHG_TWO_PRE_THRESH 6
`define CHG_TWO_LDO 5
`define CHG_TWO_TMR_EN 4
`define CHG_TWO_VREG_HI 3
`define CHG_TWO_VREG_LO 2
`define CHG_TWO_ON_HI 1
`define CHG_TWO_BOOT 0
// Field positions in the third configuration register.
`define CHG_THREE_ON_LO 7
`define CHG_THREE_SYSV_HI 6
`define CHG_THREE_SYSV_LO 5
`define CHG_THREE_PRE_TMR 4
`define CHG_THREE_TERMINATION_CURRENT_FACTOR_HI 3
`define CHG_THREE_TERMINATION_CURRENT_FACTOR_LO 2
`define CHG_THREE_IPRE_HI 1
`define CHG_THREE_IPRE_LO 0
// Timer lengths in minutes.
`define CHG_SAFETY_4H_MIN 16'd240
`define CHG_SAFETY_6H_MIN 16'd360
`define CHG_SAFETY_8H_MIN 16'd480
`define CHG_PRE_30_MIN 16'd30
`define CHG_PRE_60_MIN 16'd60
// One minute in seconds, and the clock rate in hertz.
`define CHG_MINUTE_S 60
`define CHG_CLK_HZ 100000000
`endif

// ### core/chg_pkg.sv
package chg_pkg;
  // Charge phases, in the order a normal cycle walks through them.
  typedef enum logic [2:0] {
    CHG_IDLE, CHG_PRECHARGE, CHG_CONST_CURRENT, CHG_CONST_VOLTAGE, CHG_DONE, CHG_FAULT
  } chg_phase_e;
  // Comparator and system inputs, all asynchronous to sys_clk.
  typedef struct packed {
    logic charger_input_short;
    logic below_precharge_threshold;
    logic battery_short;
    logic die_over_temp;
    logic system_below_threshold;
    logic at_regulation_voltage;
    logic below_termination_current;
    logic step_down_converter_two_on;
    logic sleep_state;
    logic boot_in_progress;
    logic voltage_range_bit;
  } chg_sense_s;
  // Settings driven to the analogue charger loops.
  typedef struct packed {
    logic charge_enable;
    logic use_precharge_current;
    logic foldback;
    logic [1:0] fast_current_scale;
    logic [1:0] precharge_current_factor;
    logic [1:0] termination_current_factor;
    logic [2:0] regulation_voltage_select;
    logic [1:0] system_voltage_threshold;
    logic precharge_threshold_select;
    logic thermistor_bias_on;
    logic discharge_switch_enable;
    logic termination_enable;
    logic converter_two_tracking;
  } chg_ctrl_s;
  // Fault flags reported by the control logic.
  typedef struct packed {
    logic input_short;
    logic battery_short;
    logic safety_timeout;
    logic precharge_timeout;
  } chg_fault_s;
endpackage

// ### core/chg_ctrl.sv
`timescale 1ns/1ps
`include "chg_defines.svh"
// Notes on behaviour
// R1 - Charge walks precharge, constant current, constant voltage.
// R2 - Reduce current when hot or system low.
// R3 - Enabled charger limits current or holds voltage.
// R4 - Below precharge threshold selects precharge current.
// R5 - Protection loops override current and voltage loops.
// R6 - Three comparators flag faults and steer converter.
// R7 - Safety timer code selects four, six, eight hours.
// R8 - Current scaling field scales fast-charge current.
// R9 - Discharge, bias, termination off, suspend bits.
// R10 - Second register: dynamic timer, threshold, LDO, timer, boot.
// R11 - Third register bits 6:5 pick system threshold.
// R12 - Precharge timer is thirty or sixty minutes.
// R13 - Third register bits 3:2 pick termination factor.
// R14 - Third register bits 1:0 pick precharge factor.
// R15 - Charger on code split across two registers.
// R16 - Regulation voltage combines range bit and field.
// R17 - Active charger forces thermistor bias on.
// R18 - LDO mode: no termination, timers reset, no discharge.
// R19 - Host clears charger-on after pack removal.
module chg_ctrl
  import chg_pkg::*;
#(
  parameter longint MINUTE_CYCLES = longint'(`CHG_MINUTE_S) * longint'(`CHG_CLK_HZ)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire chg_sense_s sense_in,
  output chg_ctrl_s ctrl_out,
  output chg_fault_s fault_out,
  output chg_phase_e phase_out
);

  // The three configuration registers.
  logic [7:0] charger_config_one;
  logic [7:0] charger_config_two;
  logic [7:0] charger_config_three;
  // Two-stage synchroniser for the comparator inputs.
  chg_sense_s sense_meta;
  chg_sense_s sense;
  // Current phase and its next value.
  chg_phase_e phase;
  chg_phase_e next_phase;
  // Minute prescaler, minute tick and the two minute counters.
  logic [63:0] prescale;
  logic minute_tick;
  logic [15:0] safety_minutes;
  logic [15:0] precharge_minutes;
  // Decoded controls.
  logic charger_on;
  logic ldo_mode;
  logic foldback;
  logic safety_expired;
  logic precharge_expired;

  // Maps the safety timer code to minutes; the unlisted code 01 falls back to the shortest time.
  function automatic logic [15:0] safety_limit(input logic [1:0] code);
    case (code)
      2'b10: safety_limit = `CHG_SAFETY_6H_MIN; // see R7
      2'b11: safety_limit = `CHG_SAFETY_8H_MIN; // see R7
      default: safety_limit = `CHG_SAFETY_4H_MIN; // see R7
    endcase
  endfunction

  // Register writes; unmatched addresses are ignored.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      charger_config_one <= `CHG_RST_CONFIG_ONE;
      charger_config_two <= `CHG_RST_CONFIG_TWO;
      charger_config_three <= `CHG_RST_CONFIG_THREE;
    end else if (reg_write) begin
      if (reg_addr == `CHG_ADDR_CONFIG_ONE) begin
        charger_config_one <= reg_wdata;
      end else if (reg_addr == `CHG_ADDR_CONFIG_TWO) begin
        charger_config_two <= reg_wdata;
      end else if (reg_addr == `CHG_ADDR_CONFIG_THREE) begin
        charger_config_three <= reg_wdata;
      end
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `CHG_ADDR_CONFIG_ONE) begin
      reg_rdata <= charger_config_one;
    end else if (reg_addr == `CHG_ADDR_CONFIG_TWO) begin
      reg_rdata <= charger_config_two;
    end else if (reg_addr == `CHG_ADDR_CONFIG_THREE) begin
      reg_rdata <= charger_config_three;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Comparators are analogue, so every bit passes two flops before use.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sense_meta <= '0;
      sense <= '0;
    end else begin
      sense_meta <= sense_in;
      sense <= sense_meta;
    end
  end

  // Charger on code: upper bit in the second register, lower in the third.
  // In sleep code 1x turns the charger on; in normal operation only 11 does.
  always_comb begin
    logic [1:0] on_code;
    on_code = {charger_config_two[`CHG_TWO_ON_HI], charger_config_three[`CHG_THREE_ON_LO]}; // see R15
    charger_on = sense.step_down_converter_two_on && on_code[1] && (sense.sleep_state || on_code[0]);
    // During boot charging is held off unless boot charging is allowed.
    if (sense.boot_in_progress && !charger_config_two[`CHG_TWO_BOOT]) begin // see R10
      charger_on = 1'b0;
    end
    // Suspend stops charging while keeping the configuration.
    if (charger_config_one[`CHG_ONE_SUSPEND]) begin // see R9
      charger_on = 1'b0;
    end
  end

  // LDO mode needs the LDO bit and termination disabled together.
  assign ldo_mode = charger_config_two[`CHG_TWO_LDO] && charger_config_one[`CHG_ONE_TERM_OFF]; // see R10
  // Thermal and system-voltage loops both pull the current down.
  assign foldback = sense.die_over_temp || sense.system_below_threshold; // see R2
  assign safety_expired = charger_config_two[`CHG_TWO_TMR_EN] &&
    (safety_minutes >= safety_limit({charger_config_one[`CHG_ONE_TMR_HI], charger_config_one[`CHG_ONE_TMR_LO]}));
  assign precharge_expired = charger_config_two[`CHG_TWO_TMR_EN] &&
    (precharge_minutes >= (charger_config_three[`CHG_THREE_PRE_TMR] ? `CHG_PRE_60_MIN : `CHG_PRE_30_MIN)); // see R12

  // One-minute enable pulse; the length is a parameter so simulation can shorten it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prescale <= 64'h0;
      minute_tick <= 1'b0;
    end else if (prescale >= 64'(MINUTE_CYCLES - 1)) begin
      prescale <= 64'h0;
      minute_tick <= 1'b1;
    end else begin
      prescale <= prescale + 64'h1;
      minute_tick <= 1'b0;
    end
  end

  // Safety and precharge timers. Dynamic timing pauses them during foldback,
  // trading a longer cycle for no false timeouts under a weak supply.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      safety_minutes <= 16'h0;
      precharge_minutes <= 16'h0;
    end else if (ldo_mode || phase == CHG_IDLE || phase == CHG_FAULT) begin // see R18
      safety_minutes <= 16'h0;
      precharge_minutes <= 16'h0;
    end else if (minute_tick && !(charger_config_two[`CHG_TWO_DYN_TIMER] && foldback)) begin // see R10
      if (safety_minutes != 16'hFFFF) begin
        safety_minutes <= safety_minutes + 16'h1;
      end
      if (phase == CHG_PRECHARGE && precharge_minutes != 16'hFFFF) begin
        precharge_minutes <= precharge_minutes + 16'h1;
      end
    end
  end

  // Phase selection. Charger off wins, then faults, then a low battery forces precharge.
  always_comb begin
    next_phase = phase;
    case (phase)
      CHG_FAULT: begin
        // A fault holds until the host turns the charger off.
        if (!charger_on) begin
          next_phase = CHG_IDLE;
        end
      end
      default: begin
        if (!charger_on) begin
          next_phase = CHG_IDLE;
        end else if (sense.charger_input_short || sense.battery_short) begin // see R6
          next_phase = CHG_FAULT;
        end else if (safety_expired || (phase == CHG_PRECHARGE && precharge_expired)) begin // see R7
          next_phase = CHG_FAULT;
        end else if (sense.below_precharge_threshold) begin // see R4
          next_phase = CHG_PRECHARGE;
        end else if (phase == CHG_IDLE || phase == CHG_PRECHARGE) begin // see R1
          next_phase = CHG_CONST_CURRENT;
        end else if (phase == CHG_CONST_CURRENT && sense.at_regulation_voltage) begin // see R1
          next_phase = CHG_CONST_VOLTAGE;
        end else if (phase == CHG_CONST_VOLTAGE && sense.below_termination_current &&
                     !charger_config_one[`CHG_ONE_TERM_OFF] && !ldo_mode) begin // see R18
          next_phase = CHG_DONE;
        end
      end
    endcase
  end

  // Phase register.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= CHG_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Registered phase output.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_out <= CHG_IDLE;
    end else begin
      phase_out <= next_phase;
    end
  end

  // Fault flags follow the fault phase; they clear when the charger is turned off.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fault_out <= '0;
    end else if (next_phase == CHG_FAULT) begin
      fault_out.input_short <= fault_out.input_short | sense.charger_input_short; // see R6
      fault_out.battery_short <= fault_out.battery_short | sense.battery_short; // see R6
      fault_out.safety_timeout <= fault_out.safety_timeout | safety_expired; // see R7
      fault_out.precharge_timeout <= fault_out.precharge_timeout |
        (phase == CHG_PRECHARGE && precharge_expired); // see R12
    end else begin
      fault_out <= '0;
    end
  end

  // Settings for the analogue loops, all registered.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_out <= '0;
    end else begin
      // Current or voltage loop runs only in the active charging phases.
      ctrl_out.charge_enable <= (next_phase == CHG_PRECHARGE || next_phase == CHG_CONST_CURRENT ||
                                 next_phase == CHG_CONST_VOLTAGE); // see R3
      ctrl_out.use_precharge_current <= sense.below_precharge_threshold; // see R4
      // Foldback overrides whatever loop is regulating.
      ctrl_out.foldback <= foldback; // see R5
      ctrl_out.fast_current_scale <= {charger_config_one[`CHG_ONE_ISCALE_HI],
                                      charger_config_one[`CHG_ONE_ISCALE_LO]}; // see R8
      ctrl_out.precharge_current_factor <= {charger_config_three[`CHG_THREE_IPRE_HI],
                                            charger_config_three[`CHG_THREE_IPRE_LO]}; // see R14
      ctrl_out.termination_current_factor <= {charger_config_three[`CHG_THREE_TERMINATION_CURRENT_FACTOR_HI],
                                              charger_config_three[`CHG_THREE_TERMINATION_CURRENT_FACTOR_LO]}; // see R13
      ctrl_out.regulation_voltage_select <= {sense.voltage_range_bit, charger_config_two[`CHG_TWO_VREG_HI],
                                             charger_config_two[`CHG_TWO_VREG_LO]}; // see R16
      ctrl_out.system_voltage_threshold <= {charger_config_three[`CHG_THREE_SYSV_HI],
                                            charger_config_three[`CHG_THREE_SYSV_LO]}; // see R11
      ctrl_out.precharge_threshold_select <= charger_config_two[`CHG_TWO_PRE_THRESH]; // see R10
      // An active charger needs the thermistor to qualify the pack.
      ctrl_out.thermistor_bias_on <= charger_config_one[`CHG_ONE_THERM_BIAS] || charger_on; // see R17
      ctrl_out.discharge_switch_enable <= charger_config_one[`CHG_ONE_DISCHARGE] && !ldo_mode; // see R18
      ctrl_out.termination_enable <= !charger_config_one[`CHG_ONE_TERM_OFF] && !ldo_mode; // see R9
      // Converter two tracks the battery only in fast charge with no fault.
      ctrl_out.converter_two_tracking <= (next_phase == CHG_CONST_CURRENT ||
                                          next_phase == CHG_CONST_VOLTAGE) &&
                                         !sense.below_precharge_threshold; // see R6
    end
  end

endmodule

// ### test/chg_host_model.sv
`timescale 1ns/1ps
// Host side of the register port.
// Requests change only just after a rising edge.
module chg_host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata
);
  // The port is idle from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end
  // A write is a one-cycle strobe.
  // The data is inverted once it is taken, so a stale byte is never mistaken for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // The address stays put until the next request replaces it.
  task automatic point(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
  endtask
  // After pack removal the upper charger-on bit is cleared at once.
  task automatic drop(input logic [7:0] two);
    wr(8'h4A, two & 8'hFD);
  endtask
endmodule

// ### test/chg_ctrl_sva.sv
`timescale 1ns/1ps
`include "chg_defines.svh"
// Port checker; it rebuilds the register images from the write strobe.
module chg_ctrl_sva
  import chg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire chg_sense_s sense_in,
  input wire chg_ctrl_s ctrl_out,
  input wire chg_fault_s fault_out,
  input wire chg_phase_e phase_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] one; // Image of the first register.
  logic [7:0] two; // Image of the second register.
  logic [7:0] three; // Image of the third register.
  logic [7:0] exp_rd; // Read data expected next.
  // The images take only writes that hit one of the three addresses.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      one <= `CHG_RST_CONFIG_ONE;
      two <= `CHG_RST_CONFIG_TWO;
      three <= `CHG_RST_CONFIG_THREE;
    end else if (reg_write) begin
      if (reg_addr == 8'h49) one <= reg_wdata;
      if (reg_addr == 8'h4A) two <= reg_wdata;
      if (reg_addr == 8'h4B) three <= reg_wdata;
    end
  end
  // Reads show the register as it stood before the edge.
  // Unmapped places read as zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      exp_rd <= 8'h00;
    end else begin
      exp_rd <= reg_addr == 8'h49 ? one : reg_addr == 8'h4A ? two : reg_addr == 8'h4B ? three : 8'h00;
    end
  end
  // Heat or a low system node, held long enough to pass the synchroniser.
  sequence s_hot;
    (sense_in.die_over_temp || sense_in.system_below_threshold) [*4];
  endsequence
  a_read_back: assert property (reg_rdata == exp_rd)
    else $error("read data does not match the register image");
  a_field_copy: assert property ($past(nrst) |-> ctrl_out.fast_current_scale == $past(one[3:2]) &&
      ctrl_out.termination_current_factor == $past(three[3:2]) && ctrl_out.precharge_current_factor == $past(three[1:0])
      && ctrl_out.system_voltage_threshold == $past(three[6:5]) && ctrl_out.precharge_threshold_select == $past(two[6]))
    else $error("a configuration field did not reach the charger");
  a_off_code: assert property (!two[1] [*4] |-> !ctrl_out.charge_enable)
    else $error("charging with the charger-on bit clear");
  a_suspend_stop: assert property (one[0] [*4] |-> !ctrl_out.charge_enable)
    else $error("charging while suspended");
  a_bias_forced: assert property (ctrl_out.charge_enable |-> ctrl_out.thermistor_bias_on)
    else $error("thermistor bias off while charging");
  a_ldo_limits: assert property ((two[5] && one[1]) [*4] |->
      !ctrl_out.termination_enable && !ctrl_out.discharge_switch_enable)
    else $error("termination or discharge left on in low-drop-out mode");
  a_fault_stop: assert property (phase_out == CHG_FAULT |-> !ctrl_out.charge_enable)
    else $error("charging in the fault phase");
  a_phase_order: assert property ($changed(phase_out) && phase_out == CHG_CONST_VOLTAGE |->
      $past(phase_out) == CHG_CONST_CURRENT)
    else $error("constant voltage entered from a phase other than constant current");
  a_precharge_use: assert property (phase_out == CHG_PRECHARGE |-> ctrl_out.use_precharge_current)
    else $error("pre-charge phase without the pre-charge current");
  a_foldback_on: assert property (s_hot ##0 ctrl_out.charge_enable |-> ctrl_out.foldback)
    else $error("no current foldback while hot or with a low system node");
endmodule
bind chg_ctrl chg_ctrl_sva i_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sense_in(sense_in), .ctrl_out(ctrl_out), .fault_out(fault_out),
  .phase_out(phase_out));

// ### test/charger_control_register_bank_tb_top.sv
`timescale 1ns/1ps
`include "chg_defines.svh"
// The drivers note expected results, and a monitor compares them in order.
module charger_control_register_bank_tb_top
  import chg_pkg::*;
;
  localparam longint MIN_CYC = 10; // Cycles in one minute, so the timers stay short.
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr;
  logic reg_write;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  chg_sense_s sense_in = '0;
  chg_ctrl_s ctrl_out;
  chg_fault_s fault_out;
  chg_phase_e phase_out;
  int err_count = 0;
  int checked = 0;
  integer seed = 32'h850d02f7;
  logic take = 1'b0; // Offers a result to the monitor.
  logic [3:0] sel = 4'h0; // Says which result is offered.
  logic [15:0] exp_q[$]; // Expected results, oldest first.
  logic [7:0] r1 = `CHG_RST_CONFIG_ONE; // The bench's own register images.
  logic [7:0] r2 = `CHG_RST_CONFIG_TWO;
  logic [7:0] r3 = `CHG_RST_CONFIG_THREE;
  logic [31:0] d;
  string nm[6] = '{"rdata", "phase", "drive", "fault", "fields", "ldo"};
  logic [10:0] sv[7] = '{11'h208, 11'h008, 11'h088, 11'h048, 11'h028, 11'h038, 11'h208};
  logic [2:0] ph[7] = '{CHG_PRECHARGE, CHG_CONST_CURRENT, CHG_CONST_CURRENT, CHG_CONST_CURRENT,
    CHG_CONST_VOLTAGE, CHG_DONE, CHG_PRECHARGE};
  // Tracking, enable, pre-charge current, bias and foldback for each profile step.
  logic [4:0] dv[7] = '{5'h0E, 5'h1A, 5'h1B, 5'h1B, 5'h1A, 5'h02, 5'h0E};
  int mins[5] = '{30, 60, 240, 360, 480};
  always #5 sys_clk = ~sys_clk;
  chg_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata));
  chg_ctrl #(.MINUTE_CYCLES(MIN_CYC)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sense_in(sense_in), .ctrl_out(ctrl_out), .fault_out(fault_out),
    .phase_out(phase_out));
  // Compares one result and counts it.
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Gathers the outputs that make up one kind of result.
  function automatic logic [15:0] view(input logic [3:0] s);
    case (s)
      4'h0: view = {8'h00, reg_rdata};
      4'h1: view = {13'h0, phase_out};
      4'h2: view = {11'h0, ctrl_out.converter_two_tracking, ctrl_out.charge_enable, ctrl_out.use_precharge_current,
        ctrl_out.thermistor_bias_on, ctrl_out.foldback};
      4'h3: view = {12'h0, fault_out};
      4'h4: view = {4'h0, ctrl_out.regulation_voltage_select, ctrl_out.fast_current_scale,
        ctrl_out.precharge_current_factor, ctrl_out.termination_current_factor, ctrl_out.system_voltage_threshold,
        ctrl_out.precharge_threshold_select};
      default: view = {14'h0, ctrl_out.termination_enable, ctrl_out.discharge_switch_enable};
    endcase
  endfunction
  // The monitor takes the oldest note whenever a result is offered.
  always @(posedge sys_clk) begin
    if (take) begin
      chk(nm[sel], view(sel), exp_q.pop_front());
    end
  end
  // Notes a value, then offers the result for exactly one edge.
  task automatic note(input logic [3:0] s, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    take <= 1'b1;
    sel <= s;
    @(posedge sys_clk);
    take <= 1'b0;
  endtask
  // Writes a register, keeps the image, and waits for the outputs to follow.
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    i_host.wr(a, v);
    if (a == 8'h49) r1 = v;
    if (a == 8'h4A) r2 = v;
    if (a == 8'h4B) r3 = v;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.point(a);
    note(4'h0, {8'h00, e});
  endtask
  // Sets the comparator levels, then lets them pass the synchroniser.
  task automatic step(input logic [10:0] s, input int n);
    @(posedge sys_clk);
    sense_in <= s;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic off();
    i_host.drop(r2);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h49, `CHG_RST_CONFIG_ONE);
    rd(8'h4A, `CHG_RST_CONFIG_TWO);
    rd(8'h4B, `CHG_RST_CONFIG_THREE);
    rd(8'h4C, 8'h00);
    $display("test reset done");
    // Random images, with a write to an unmapped place that must change nothing.
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      step({10'h0, d[24]}, 1);
      put(8'h49, d[7:0]);
      put(8'h4A, d[15:8]);
      put(8'h4B, d[23:16]);
      put(8'h48, d[31:24]);
      rd(8'h49, r1);
      rd(8'h4A, r2);
      rd(8'h4B, r3);
      note(4'h4, {4'h0, d[24], r2[3:2], r1[3:2], r3[1:0], r3[3:2], r3[6:5], r2[6]});
    end
    $display("test registers done");
    put(8'h49, 8'h0C);
    put(8'h4A, 8'h1A);
    put(8'h4B, 8'h80);
    // A full charge profile, with heat and a low system node on the way.
    for (int i = 0; i < 7; i++) begin
      step(sv[i], 6);
      note(4'h1, {13'h0, ph[i]});
      note(4'h2, {11'h0, dv[i]});
    end
    $display("test profile done");
    for (int k = 0; k < 8; k++) begin
      put(8'h4A, {r2[7:2], k[2], r2[0]});
      put(8'h4B, {k[1], r3[6:0]});
      step({8'h01, k[0], 2'b00}, 6);
      note(4'h2, {11'h0, (k[2] & (k[1] | k[0])) ? 5'h1A : 5'h00});
    end
    put(8'h49, 8'h0D);
    note(4'h2, 16'h0);
    put(8'h49, 8'h0C);
    // Boot holds the charger off until boot charging is allowed.
    step(11'h00A, 6);
    note(4'h2, 16'h0);
    put(8'h4A, r2 | 8'h01);
    note(4'h2, 16'h1A);
    put(8'h4A, r2 & 8'hFE);
    $display("test enable done");
    // Each short fault latches and is left only by switching the charger off.
    for (int j = 0; j < 2; j++) begin
      step(j ? 11'h108 : 11'h408, 6);
      note(4'h3, j ? 16'h4 : 16'h8);
      step(11'h008, 6);
      note(4'h1, {13'h0, CHG_FAULT});
      off();
      note(4'h3, 16'h0);
      put(8'h4A, r2);
    end
    put(8'h49, 8'h2E);
    note(4'h5, 16'h1);
    put(8'h4A, r2 | 8'h20);
    note(4'h5, 16'h0);
    put(8'h4A, r2 & 8'hDF);
    put(8'h49, 8'h0C);
    $display("test faults done");
    // Timer lengths, from just before to just after each expiry.
    for (int t = 0; t < 5; t++) begin
      off();
      put(8'h49, {t == 3 ? 2'b10 : t == 4 ? 2'b11 : 2'b00, 6'h0C});
      put(8'h4B, {r3[7:5], t[0], r3[3:0]});
      step(t < 2 ? 11'h208 : 11'h008, 1);
      put(8'h4A, r2);
      repeat (mins[t] * MIN_CYC - 30) @(posedge sys_clk);
      note(4'h3, 16'h0);
      repeat (50) @(posedge sys_clk);
      note(4'h3, t < 2 ? 16'h1 : 16'h2);
    end
    // Dynamic timing freezes the pre-charge timer while the die is hot.
    off();
    step(11'h288, 1);
    put(8'h4A, r2 | 8'h80);
    repeat (350) @(posedge sys_clk);
    note(4'h3, 16'h0);
    step(11'h208, 1);
    repeat (330) @(posedge sys_clk);
    note(4'h3, 16'h1);
    $display("test timers done");
    tally_and_finish();
  end
  // Watchdog, well beyond the length of the whole sequence.
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    tally_and_finish();
  end
endmodule
